// file: src/stp_prescaler.sv
`timescale 1ns/1ns
`include "stp_consts.svh"

// Operation
// - Code one counts every system clock
// - Taps divide by 8, 64, 256, 1024
// - Free-running prescaler shared by both timers
// - First prescaled count within 1..N+1 clocks
// - Prescaler reset restarts both timers' periods
// - Count pin synchronised every system clock
// - Single pulse per rising/falling edge selected
// - Count lands 2 to 3 clocks after edge
// - External pulses drive timer undivided
// - Hold keeps written prescaler reset bits
// - Clearing hold clears shared bit; async bit waits for done in async mode
// - Async reset bit self-clears unless held or async mode reset not done
// - Shared reset bit self-clears unless held
// - Register at data 0x43, I/O 0x23
// - Code zero stops the timer
module stp_prescaler #(
	parameter int PRESCALE_W = `STP_PRESCALE_W
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Register port
	input wire logic [7:0] ADDR,
	input wire logic IO_SPACE,
	input wire logic WR_EN,
	input wire logic RD_EN,
	input wire logic [7:0] WDATA,
	output logic [7:0] RDATA,
	output logic HIT,
	// Clock selects of the two timers
	input wire logic [2:0] FIRST_TIMER_CLOCK_SELECT,
	input wire logic [2:0] WIDE_TIMER_CLOCK_SELECT,
	// External count pins
	input wire logic FIRST_EXTERNAL_COUNT_PIN,
	input wire logic WIDE_EXTERNAL_COUNT_PIN,
	// Third timer prescaler handshake
	input wire logic ASYNC_MODE,
	input wire logic ASYNC_RESET_DONE,
	output logic ASYNC_PRESCALER_RESET,
	// Timer count enables
	output logic FIRST_TIMER_COUNT_CLOCK,
	output logic WIDE_TIMER_COUNT_CLOCK
);
	logic [PRESCALE_W-1:0] prescale;
	logic [PRESCALE_W-1:0] next_prescale;
	logic sync_hold_mode;
	logic shared_prescaler_reset;
	logic async_prescaler_reset;
	logic next_hold;
	logic next_shared_rst;
	logic next_async_rst;
	logic sel;
	logic wr;
	logic [3:0] tap;
	stp_pkg::stp_clk_sel_t cs [2];
	logic [1:0] pin;
	logic [1:0] rise;
	logic [1:0] fall;
	logic [1:0] count_clk;
	stp_pkg::stp_space_t space;

	always_comb begin
		space = stp_pkg::STP_ACC_NONE;
		if (!IO_SPACE && ADDR == `STP_GTC_DATA_ADDR) begin
			space = stp_pkg::STP_ACC_DATA;
		end else if (IO_SPACE && ADDR == `STP_GTC_IO_ADDR) begin
			space = stp_pkg::STP_ACC_IO;
		end
	end
	assign sel = (space != stp_pkg::STP_ACC_NONE);
	assign wr = sel & WR_EN;

	// Control register next state
	always_comb begin
		next_hold = sync_hold_mode;
		next_shared_rst = shared_prescaler_reset;
		next_async_rst = async_prescaler_reset;
		if (wr) begin
			next_hold = WDATA[`STP_BIT_HOLD];
			next_shared_rst = WDATA[`STP_BIT_SHARED_RST] |
				shared_prescaler_reset;
			next_async_rst = WDATA[`STP_BIT_ASYNC_RST] |
				async_prescaler_reset;
		end
		if (!next_hold) begin
			// Reset has acted on the prescaler by now; clearing is safe
			if (shared_prescaler_reset) begin
				next_shared_rst = 1'b0;
			end
			if (async_prescaler_reset &&
				(!ASYNC_MODE || ASYNC_RESET_DONE)) begin
				next_async_rst = 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			sync_hold_mode <= 1'b0;
			shared_prescaler_reset <= 1'b0;
			async_prescaler_reset <= 1'b0;
		end else begin
			sync_hold_mode <= next_hold;
			shared_prescaler_reset <= next_shared_rst;
			async_prescaler_reset <= next_async_rst;
		end
	end

	assign ASYNC_PRESCALER_RESET = async_prescaler_reset;

	// Free-running shared divider, cleared by its own reset bit and by RST_N
	always_comb begin
		if (shared_prescaler_reset) begin
			next_prescale = '0;
		end else begin
			next_prescale = prescale + 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			prescale <= '0;
		end else begin
			prescale <= next_prescale;
		end
	end

	// Taps pulse once per period while the prescaler runs
	// A held reset gates every tap, so prescaled timers stay halted
	always_comb begin
		tap[0] = &prescale[`STP_TAP8_BITS-1:0] &
			~shared_prescaler_reset;
		tap[1] = &prescale[`STP_TAP64_BITS-1:0] &
			~shared_prescaler_reset;
		tap[2] = &prescale[`STP_TAP256_BITS-1:0] &
			~shared_prescaler_reset;
		tap[3] = &prescale[`STP_TAP1024_BITS-1:0] &
			~shared_prescaler_reset;
	end

	assign cs[0] = FIRST_TIMER_CLOCK_SELECT;
	assign cs[1] = WIDE_TIMER_CLOCK_SELECT;
	assign pin[0] = FIRST_EXTERNAL_COUNT_PIN;
	assign pin[1] = WIDE_EXTERNAL_COUNT_PIN;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_timer
			stp_ext_edge u_edge (
				.clk(CLK_SYS),
				.rst_n(RST_N),
				.pin(pin[g]),
				.rising(cs[g] == `STP_CS_EXT_RISE),
				.rise_pulse(rise[g]),
				.fall_pulse(fall[g])
			);
			always_comb begin
				case (cs[g])
					`STP_CS_STOP: count_clk[g] = 1'b0;
					`STP_CS_DIRECT: count_clk[g] = 1'b1;
					`STP_CS_DIV8: count_clk[g] = tap[0];
					`STP_CS_DIV64: count_clk[g] = tap[1];
					`STP_CS_DIV256: count_clk[g] = tap[2];
					`STP_CS_DIV1024: count_clk[g] = tap[3];
					`STP_CS_EXT_FALL: count_clk[g] = fall[g];
					default: count_clk[g] = rise[g];
				endcase
			end
		end
	endgenerate

	// Count enables are strobes, so they stay combinational
	assign FIRST_TIMER_COUNT_CLOCK = count_clk[0];
	assign WIDE_TIMER_COUNT_CLOCK = count_clk[1];

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			RDATA <= `STP_GTC_RESET;
		end else if (sel && RD_EN) begin
			RDATA <= {sync_hold_mode, 5'h00, async_prescaler_reset,
				shared_prescaler_reset};
		end else begin
			RDATA <= 8'h00;
		end
	end
	assign HIT = sel;

	AST_DIRECT: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(FIRST_TIMER_CLOCK_SELECT == `STP_CS_DIRECT) |->
		FIRST_TIMER_COUNT_CLOCK) else $error("Direct clock missing");
	AST_STOP: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(WIDE_TIMER_CLOCK_SELECT == `STP_CS_STOP) |->
		!WIDE_TIMER_COUNT_CLOCK) else $error("Stopped timer counted");
	AST_DIV8: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(tap[0] && !shared_prescaler_reset) ##1 !shared_prescaler_reset
		[*8] |-> tap[0]) else $error("Divide by 8 period wrong");
	AST_TAP_ORDER: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		tap[3] |-> tap[2] && tap[1] && tap[0])
		else $error("Taps misaligned");
	AST_HOLD_KEEP: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(sync_hold_mode && shared_prescaler_reset && !wr) |=>
		shared_prescaler_reset) else $error("Held reset cleared");
	AST_RELEASE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		($fell(sync_hold_mode) && !wr) |-> !shared_prescaler_reset &&
		(!async_prescaler_reset || ASYNC_MODE))
		else $error("Release did not clear resets");
	AST_SELF_CLEAR: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(shared_prescaler_reset && !sync_hold_mode && !wr) |=>
		!shared_prescaler_reset) else $error("Reset bit stuck");
	AST_ASYNC_CLEAR: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(async_prescaler_reset && !ASYNC_MODE && !sync_hold_mode && !wr)
		|=> !async_prescaler_reset) else $error("Async bit stuck");
	AST_RESTART: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		shared_prescaler_reset |=> prescale == '0)
		else $error("Prescaler not restarted");
	AST_IO_ALIAS: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(IO_SPACE && ADDR == `STP_GTC_DATA_ADDR - `STP_IO_SPACE_OFFSET)
		|-> HIT) else $error("I/O alias missed");
endmodule

// file: src/stp_consts.svh
`ifndef STP_CONSTS_SVH
`define STP_CONSTS_SVH

// Register decode
`define STP_GTC_DATA_ADDR 8'h43
`define STP_IO_SPACE_OFFSET 8'h20
`define STP_GTC_IO_ADDR 8'h23

// Field positions of the general timer control register
`define STP_BIT_SHARED_RST 0
`define STP_BIT_ASYNC_RST 1
`define STP_BIT_HOLD 7
`define STP_GTC_RESET 8'h00

// Clock select codes
`define STP_CS_STOP 3'h0
`define STP_CS_DIRECT 3'h1
`define STP_CS_DIV8 3'h2
`define STP_CS_DIV64 3'h3
`define STP_CS_DIV256 3'h4
`define STP_CS_DIV1024 3'h5
`define STP_CS_EXT_FALL 3'h6
`define STP_CS_EXT_RISE 3'h7

// Prescaler tap bit positions (tap pulses when these low bits are all ones)
`define STP_TAP8_BITS 3
`define STP_TAP64_BITS 6
`define STP_TAP256_BITS 8
`define STP_TAP1024_BITS 10
`define STP_PRESCALE_W 10

`endif

// file: src/stp_pkg.sv
package stp_pkg;
	typedef logic [2:0] stp_clk_sel_t;
	typedef enum logic [1:0] {
		STP_ACC_NONE = 2'b00,
		STP_ACC_DATA = 2'b01,
		STP_ACC_IO = 2'b10
	} stp_space_t;
endpackage

// file: src/stp_ext_edge.sv
`timescale 1ns/1ns
`include "stp_consts.svh"

// Count pin synchroniser and edge detector for one timer
module stp_ext_edge (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pin and edge choice
	input wire logic pin,
	input wire logic rising,
	// One-cycle count pulses
	output logic rise_pulse,
	output logic fall_pulse
);
	logic sync_a;
	logic sync_b;
	logic last;
	logic next_sync_a;
	logic next_sync_b;
	logic next_last;

	always_comb begin
		next_sync_a = pin;
		next_sync_b = sync_a;
		next_last = sync_b;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			last <= 1'b0;
		end else begin
			sync_a <= next_sync_a;
			sync_b <= next_sync_b;
			last <= next_last;
		end
	end

	// Only the second stage and its delayed copy are compared
	// Each pulse is gated by the edge choice so only one kind leaves
	assign rise_pulse = sync_b & ~last & rising;
	assign fall_pulse = ~sync_b & last & ~rising;

	AST_ONE_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
		rise_pulse |=> !rise_pulse) else $error("Rise pulse too long");
	AST_PIN_DELAY: assert property (@(posedge clk) disable iff (!rst_n)
		(rising && pin && !sync_a && !sync_b && !last) ##2 rising
		|-> rise_pulse)
		else $error("Edge not seen within three clocks");
endmodule

// file: testbench/stp_pin_src.sv
`timescale 1ns/1ns
// Count pin source; finishes the half period under way at disable, then keeps its level so enable changes are safe
// Half period is whole clocks, so edges land away from the sampling edge
module stp_pin_src #(
	parameter int HALF_NS = 300
) (
	input wire logic en,
	output logic pin
);
	initial begin
		pin = 1'b0;
		forever begin
			wait (en);
			#HALF_NS pin = ~pin;
		end
	end
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ns
module tb;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic io_space = 1'b0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic hit;
	logic h_seen = 1'b0;
	logic [2:0] sel_f = 3'h0;
	logic [2:0] sel_w = 3'h0;
	logic pin_f;
	logic en_src = 1'b0;
	logic async_mode = 1'b0;
	logic async_done = 1'b0;
	logic async_rst;
	logic cc_f;
	logic cc_w;
	int n_errors = 0;
	int num_checks = 0;
	int seed = 80836;
	int cyc = 0;
	int cnt_f = 0;
	int cnt_w = 0;
	int edges = 0;
	int edges_all = 0;
	initial forever #50 clk_sys = ~clk_sys;
	stp_prescaler DUT (
		.CLK_SYS(clk_sys), .RST_N(rst_n), .ADDR(addr), .IO_SPACE(io_space),
		.WR_EN(wr_en), .RD_EN(rd_en), .WDATA(wdata), .RDATA(rdata),
		.HIT(hit), .FIRST_TIMER_CLOCK_SELECT(sel_f),
		.WIDE_TIMER_CLOCK_SELECT(sel_w), .FIRST_EXTERNAL_COUNT_PIN(pin_f),
		.WIDE_EXTERNAL_COUNT_PIN(pin_f), .ASYNC_MODE(async_mode),
		.ASYNC_RESET_DONE(async_done), .ASYNC_PRESCALER_RESET(async_rst),
		.FIRST_TIMER_COUNT_CLOCK(cc_f), .WIDE_TIMER_COUNT_CLOCK(cc_w)
	);
	stp_pin_src src (.en(en_src), .pin(pin_f));
	// Edges of the kind the first timer's code selects
	always @(pin_f) begin
		edges_all++;
		if (pin_f === sel_f[0])
			edges++;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		cnt_f <= cnt_f + int'(cc_f === 1'b1);
		cnt_w <= cnt_w + int'(cc_w === 1'b1);
		if (cyc == 40000) begin
			n_errors++;
			summarize();
		end
	end
	function automatic int div_of(input int c);
		case (c)
			1: return 1;
			2: return 8;
			3: return 64;
			4: return 256;
			5: return 1024;
			default: return 0;
		endcase
	endfunction
	// Counts in a window of 2048 clocks, exact for any tap phase
	function automatic int exp_cnt(input int c);
		return (c == 0) ? 0 : 2048 / div_of(c);
	endfunction
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s exp %h got %h", what, e, g);
		end
	endtask
	// Extra idle cycle lets a self-clearing bit settle
	task automatic acc(input logic io, input logic [7:0] a, input logic wr,
		input logic [7:0] d, output logic [7:0] r);
		@(negedge clk_sys);
		io_space = io;
		addr = a;
		wdata = d;
		wr_en = wr;
		rd_en = ~wr;
		@(negedge clk_sys);
		r = rdata;
		h_seen = hit;
		wr_en = 1'b0;
		rd_en = 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic summarize();
		if (n_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		int n;
		int k;
		int c;
		int m;
		int a;
		logic [7:0] r;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_n = 1'b1;
		acc(0, 8'h43, 0, 8'h00, r);
		chk("reset value", 8'h00, r);
		acc(0, 8'h44, 1, 8'h80, r);
		chk("hit unmapped", 0, h_seen);
		acc(1, 8'h23, 0, 8'h00, r);
		chk("unmapped write", 8'h00, r);
		chk("hit io", 1, h_seen);
		acc(1, 8'h23, 1, 8'h83, r);
		acc(0, 8'h43, 0, 8'h00, r);
		chk("hold bits", 8'h83, r);
		chk("async reset", 1, async_rst);
		sel_w = 3'h2;
		n = cnt_w;
		repeat (50) @(negedge clk_sys);
		chk("held tap", n, cnt_w);
		acc(1, 8'h23, 1, 8'h00, r);
		acc(1, 8'h23, 0, 8'h00, r);
		chk("hold release", 8'h00, r);
		async_mode = 1'b1;
		acc(0, 8'h43, 1, 8'h02, r);
		acc(0, 8'h43, 0, 8'h00, r);
		chk("async pending", 8'h02, r);
		async_done = 1'b1;
		acc(0, 8'h43, 0, 8'h00, r);
		chk("async done", 8'h00, r);
		for (c = 0; c < 6; c++) begin
			sel_w = 3'h0;
			sel_f = 3'(($random(seed) & 32'hff) % 6);
			acc(0, 8'h43, 1, 8'h01, r);
			sel_w = c[2:0];
			n = 0;
			while (c > 0 && cc_w !== 1'b1 && n <= div_of(c)) begin
				@(negedge clk_sys);
				n++;
			end
			chk("first tap", c > 0, cc_w === 1'b1);
			n = cnt_w;
			k = cnt_f;
			repeat (2048) @(negedge clk_sys);
			chk("wide rate", exp_cnt(c), cnt_w - n);
			chk("first rate", exp_cnt(sel_f), cnt_f - k);
		end
		sel_w = 3'h0;
		for (c = 6; c < 8; c++) begin
			sel_f = c[2:0];
			sel_w = 3'(13 - c);
			repeat (2) @(negedge clk_sys);
			n = cnt_f;
			k = edges;
			m = cnt_w;
			a = edges_all;
			en_src = 1'b1;
			repeat (20 + ($random(seed) & 63)) @(negedge clk_sys);
			en_src = 1'b0;
			repeat (6) @(negedge clk_sys);
			chk("pin count", edges - k, cnt_f - n);
			chk("wide pin count", (edges_all - a) - (edges - k),
				cnt_w - m);
		end
		summarize();
	end
endmodule
